// [verilog/tlbta_pkg.sv]
// Behaviour
// [RL1] Buffer holds 32 entries, four-way set-associative.
// [RL2] Entry stores 24-bit tag, 20-bit physical page.
// [RL3] Tag is linear page, valid, three attributes.
// [RL4] Write stores data register page into chosen entry.
// [RL5] Lookup loads selected entry data into data register.
// [RL6] Tag for both operations built from control.
// [RL7] Control bit 0: one looks up, zero writes.
// [RL8] Lookup updates fields only on exactly one match.
// [RL9] Write allocates entry to control linear page.
// [RL10] Control bit 11 sets written entry valid.
// [RL11] Three attribute pairs: dirty, user, read/write.
// [RL12] Lookup pairs mask matching: never, zero, one, any.
// [RL13] Write pair 01 clears, 10 sets attribute.
// [RL14] Data bit 4 reports lookup hit or miss.
// [RL15] Write set from select field or pseudo-LRU.
// [RL16] Data bits 3:2 report hit set.
// [RL17] Set select used only with flag set.
// [RL18] Lookup returns prior recency bits; writes ignore them.
// [RL19] Data bits 31:12 return or supply page.
// [RL20] Software loads data before control; reserved zero.
package tlbta_pkg;

  // ==========================================================================
  // Geometry
  localparam int TLBTA_ENTRIES = 32;
  localparam int TLBTA_WAYS = 4;
  localparam int TLBTA_PAGE_W = 20;
  localparam int TLBTA_TAG_W = 24;
  localparam int TLBTA_LRU_W = 3;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] TLBTA_CTRL_OFS = 12'h000;
  localparam logic [11:0] TLBTA_DATA_OFS = 12'h004;

  // ==========================================================================
  // Control register fields
  localparam int TLBTA_CMD_BIT = 0;
  localparam int TLBTA_PAGE_LSB = 12;
  localparam int TLBTA_VALID_BIT = 11;
  localparam int TLBTA_DIRTY_LSB = 9;
  localparam int TLBTA_USER_LSB = 7;
  localparam int TLBTA_RW_LSB = 5;
  localparam logic [31:0] TLBTA_CTRL_MASK = 32'hFFFF_FFE1;
  localparam logic [31:0] TLBTA_CTRL_RESET = 32'h0000_0000;

  // ==========================================================================
  // Data register fields
  localparam int TLBTA_LRU_LSB = 7;
  localparam int TLBTA_FLAG_BIT = 4;
  localparam int TLBTA_SET_LSB = 2;
  localparam logic [31:0] TLBTA_DATA_MASK = 32'hFFFF_F39C;
  localparam logic [31:0] TLBTA_DATA_RESET = 32'h0000_0000;

  // ==========================================================================
  // Bus constants
  localparam logic [2:0] TLBTA_HSIZE_WORD = 3'h2;
  localparam logic [1:0] TLBTA_HRESP_OKAY = 2'h0;

  typedef struct packed {
    logic [TLBTA_PAGE_W-1:0] page;
    logic valid;
    logic dirty;
    logic user;
    logic rw;
    logic [TLBTA_PAGE_W-1:0] phys;
  } tlbta_entry_t;

endpackage : tlbta_pkg

// [verilog/tlbta_array.sv]
`timescale 1ns/10ps
module tlbta_array
  import tlbta_pkg::*;
#(
  parameter int ENTRIES = TLBTA_ENTRIES
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Request.
  input wire logic lookup,
  input wire logic write,
  input wire logic [TLBTA_PAGE_W-1:0] page,
  input wire logic valid_in,
  input wire logic [5:0] attr_pairs,
  input wire logic [TLBTA_PAGE_W-1:0] phys_in,
  input wire logic explicit_set,
  input wire logic [1:0] set_in,
  // Lookup answer.
  output logic hit,
  output logic [1:0] hit_set,
  output tlbta_entry_t hit_entry,
  output logic [TLBTA_LRU_W-1:0] lru_before
);

  localparam int LINES = ENTRIES / TLBTA_WAYS;
  localparam int IDX_W = $clog2(LINES);

  // ==========================================================================
  // State: entries as line-major, way-minor, plus three recency bits a line.
  typedef struct packed {
    tlbta_entry_t [ENTRIES-1:0] ent;
    logic [LINES-1:0][TLBTA_LRU_W-1:0] lru;
  } tlbta_arr_t;

  tlbta_arr_t s_q;
  tlbta_arr_t s_d;

  function automatic logic pair_match(input logic [1:0] pr, input logic b);
    pair_match = b ? pr[1] : pr[0];
  endfunction : pair_match

  function automatic logic [2:0] touch(input logic [2:0] l, input logic [1:0] w);
    logic [2:0] r;
    r = l;
    r[0] = ~w[1];
    if (!w[1]) begin
      r[1] = ~w[0];
    end else begin
      r[2] = ~w[0];
    end
    touch = r;
  endfunction : touch

  // ==========================================================================
  // Lookup and write.
  always_comb begin
    logic [IDX_W-1:0] idx;
    logic [2:0] nmatch;
    logic [1:0] way;
    logic [2:0] l;
    tlbta_entry_t e;
    idx = page[IDX_W-1:0];
    way = 2'h0;
    e = '0;
    nmatch = 3'h0;
    hit_set = 2'h0;
    hit_entry = '0;
    s_d = s_q;
    l = s_q.lru[idx];
    lru_before = l; // [RL18]
    for (int w = 0; w < TLBTA_WAYS; w++) begin
      e = s_q.ent[idx * TLBTA_WAYS + w];
      if (e.valid && e.page == page && pair_match(attr_pairs[5:4], e.dirty) &&
          pair_match(attr_pairs[3:2], e.user) && pair_match(attr_pairs[1:0], e.rw)) begin // [RL12]
        nmatch = nmatch + 3'h1;
        hit_set = w[1:0];
        hit_entry = e;
      end
    end
    hit = (nmatch == 3'h1); // [RL8]
    if (lookup && hit) begin
      s_d.lru[idx] = touch(l, hit_set);
    end
    if (write) begin
      if (explicit_set) begin
        way = set_in; // [RL15] [RL17]
      end else if (l[0]) begin
        way = {1'b1, l[2]}; // [RL15]
      end else begin
        way = {1'b0, l[1]};
      end
      e.page = page; // [RL9] [RL3]
      e.valid = valid_in; // [RL10]
      e.dirty = attr_pairs[5]; // [RL13]
      e.user = attr_pairs[3];
      e.rw = attr_pairs[1];
      e.phys = phys_in; // [RL4] [RL2]
      s_d.ent[idx * TLBTA_WAYS + 32'(way)] = e; // [RL1]
      s_d.lru[idx] = touch(l, way);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : tlbta_array

// [verilog/tlbta_top.sv]
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module tlbta_top
  import tlbta_pkg::*;
#(
  parameter int ENTRIES = TLBTA_ENTRIES
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite address phase.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  // AHB-Lite data phase.
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp
);

  // ==========================================================================
  // State.
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] data;
    logic [11:0] addr;
    logic wr;
    logic [31:0] rdata;
    logic ready;
  } tlbta_main_t;

  localparam tlbta_main_t TLBTA_MAIN_RESET = '{
    ctrl: TLBTA_CTRL_RESET,
    data: TLBTA_DATA_RESET,
    addr: 12'h000,
    wr: 1'b0,
    rdata: 32'h0000_0000,
    ready: 1'b1
  };

  tlbta_main_t s_q;
  tlbta_main_t s_d;

  logic op_go;
  logic [31:0] cw;
  logic arr_hit;
  logic [1:0] arr_set;
  tlbta_entry_t arr_ent;
  logic [TLBTA_LRU_W-1:0] arr_lru;

  // ==========================================================================
  // Operation starts in the data phase of a control register write.
  assign op_go = s_q.wr && (s_q.addr == TLBTA_CTRL_OFS);
  assign cw = hwdata & TLBTA_CTRL_MASK;

  tlbta_array #(
    .ENTRIES(ENTRIES)
  ) u_array (
    .hclk(hclk),
    .hresetn(hresetn),
    .lookup(op_go && cw[TLBTA_CMD_BIT]),
    .write(op_go && !cw[TLBTA_CMD_BIT]),
    .page(cw[31:TLBTA_PAGE_LSB]),
    .valid_in(cw[TLBTA_VALID_BIT]),
    .attr_pairs(cw[TLBTA_DIRTY_LSB+1:TLBTA_RW_LSB]),
    .phys_in(s_q.data[31:TLBTA_PAGE_LSB]),
    .explicit_set(s_q.data[TLBTA_FLAG_BIT]),
    .set_in(s_q.data[TLBTA_SET_LSB+1:TLBTA_SET_LSB]),
    .hit(arr_hit),
    .hit_set(arr_set),
    .hit_entry(arr_ent),
    .lru_before(arr_lru)
  );

  // ==========================================================================
  // Register file and bus slave.
  always_comb begin
    s_d = s_q;
    s_d.ready = 1'b1;
    if (s_q.wr) begin
      if (s_q.addr == TLBTA_DATA_OFS) begin
        s_d.data = hwdata & TLBTA_DATA_MASK;
      end else if (s_q.addr == TLBTA_CTRL_OFS) begin
        s_d.ctrl = cw; // [RL6] [RL11]
      end
    end
    if (op_go && cw[TLBTA_CMD_BIT]) begin // [RL7]
      if (arr_hit) begin // [RL8] [RL5]
        s_d.ctrl[TLBTA_VALID_BIT] = arr_ent.valid;
        s_d.ctrl[TLBTA_DIRTY_LSB+1:TLBTA_DIRTY_LSB] = {arr_ent.dirty, ~arr_ent.dirty};
        s_d.ctrl[TLBTA_USER_LSB+1:TLBTA_USER_LSB] = {arr_ent.user, ~arr_ent.user};
        s_d.ctrl[TLBTA_RW_LSB+1:TLBTA_RW_LSB] = {arr_ent.rw, ~arr_ent.rw};
        s_d.data[31:TLBTA_PAGE_LSB] = arr_ent.phys; // [RL19]
        s_d.data[TLBTA_LRU_LSB+2:TLBTA_LRU_LSB] = arr_lru; // [RL18]
        s_d.data[TLBTA_FLAG_BIT] = 1'b1; // [RL14]
        s_d.data[TLBTA_SET_LSB+1:TLBTA_SET_LSB] = arr_set; // [RL16]
      end else begin
        s_d.data[TLBTA_FLAG_BIT] = 1'b0; // [RL14]
      end
    end
    s_d.wr = hsel && htrans[1] && hready && hwrite && (hsize == TLBTA_HSIZE_WORD);
    s_d.addr = haddr[11:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      if (haddr[11:0] == TLBTA_CTRL_OFS) begin
        s_d.rdata = s_d.ctrl;
      end else if (haddr[11:0] == TLBTA_DATA_OFS) begin
        s_d.rdata = s_d.data;
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= TLBTA_MAIN_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = s_q.ready;
  assign hresp = TLBTA_HRESP_OKAY;

endmodule : tlbta_top

// [dv/tlbta_checker.sv]
`timescale 1ns/10ps
module tlbta_checker
  import tlbta_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic [1:0] hresp
);
  // ==========================================================================
  // Transfer decode and checks.
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic tk = hsel & htrans[1] & hready;
  wire logic rd = tk & !hwrite;
  wire logic wr = tk & hwrite & (hsize == TLBTA_HSIZE_WORD);
  wire logic a0 = haddr[11:0] == TLBTA_CTRL_OFS;
  wire logic a4 = haddr[11:0] == TLBTA_DATA_OFS;
  AST_RDY: assert property (hreadyout) else $error("not ready");
  AST_OKAY: assert property (hresp == TLBTA_HRESP_OKAY) else $error("bad resp");
  AST_HOLD: assert property (!rd |=> $stable(hrdata)) else $error("rdata moved");
  AST_CRSV: assert property (rd && a0 |=> (hrdata & ~TLBTA_CTRL_MASK) == 0)
    else $error("ctrl reserved set");
  AST_DRSV: assert property (rd && a4 |=> (hrdata & ~TLBTA_DATA_MASK) == 0)
    else $error("data reserved set");
  AST_UNMAP: assert property (rd && haddr[11:0] > 12'h004 |=> hrdata == 0)
    else $error("unmapped read");
  AST_CTRL: assert property (wr && a0 ##1 !hwdata[0] ##1 rd && a0
    |=> hrdata == ($past(hwdata, 2) & TLBTA_CTRL_MASK)) else $error("ctrl lost");
  AST_DATA: assert property (wr && a4 ##2 rd && a4
    |=> hrdata == ($past(hwdata, 2) & TLBTA_DATA_MASK)) else $error("data lost");
  C_HIT: cover property (rd && a4 ##1 hrdata[4]);
  C_LOOK: cover property (wr && a0 ##1 hwdata[0]);
  C_UNMAP: cover property (rd && haddr[11:0] > 12'h004);
endmodule : tlbta_checker

bind tlbta_top tlbta_checker u_tlbta_checker (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp);

// [dv/tlbta_tb_top.sv]
`timescale 1ns/10ps
module tlbta_tb_top
  import tlbta_pkg::*;
;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, rd_ph = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, v, dexp = 0;
  logic [1:0] htrans = 0, hresp;
  logic [2:0] hsize = TLBTA_HSIZE_WORD, lru = 0;
  logic [19:0] pg[4], ph[4], old;
  logic [31:0] q[$];
  int n_mismatch = 0, comparisons = 0, cyc = 0, seed = 78408, k;
  always #4 hclk = ~hclk;
  tlbta_top u_tlbta_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp);
  // ==========================================================================
  // Bus master, result monitor and replacement model.
  task end_of_test;
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 2000) begin
      n_mismatch++;
      end_of_test;
    end
    if (rd_ph) chk(hrdata, q.pop_front());
    rd_ph = hsel & htrans[1] & !hwrite;
  end
  task xf(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : xf
  task rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    xf(a, 1'b0, 32'h0000_0000);
  endtask : rd
  function automatic logic [2:0] up(input logic [2:0] l, input int s);
    up = l;
    up[0] = s < 2;
    if (s < 2) up[1] = s == 0;
    else up[2] = s == 2;
  endfunction : up
  task wt(input logic [19:0] p, input logic [19:0] f, input logic fl, input logic [1:0] s);
    xf(TLBTA_DATA_OFS, 1'b1, {f, 7'h00, fl, s, 2'b00});
    xf(TLBTA_CTRL_OFS, 1'b1, {p, 12'hCC0});
  endtask : wt
  task lk(input logic [19:0] p, input logic [5:0] pr, input int s);
    xf(TLBTA_CTRL_OFS, 1'b1, {p, 1'b0, pr, 5'h01});
    if (s >= 0) begin
      dexp = {ph[s], 2'b00, lru, 2'b00, 1'b1, 2'(s), 2'b00};
      lru = up(lru, s);
    end else dexp[4] = 1'b0;
    rd(TLBTA_DATA_OFS, dexp);
  endtask : lk
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(TLBTA_CTRL_OFS, 32'h0000_0000);
    rd(12'h008, 32'h0000_0000);
    v = $random(seed);
    xf(TLBTA_DATA_OFS, 1'b1, v);
    rd(TLBTA_DATA_OFS, v & TLBTA_DATA_MASK);
    for (int s = 0; s < 4; s++) begin
      v = $random(seed);
      pg[s] = {v[19:5], 2'(s), 3'h5};
      ph[s] = v[31:12];
      wt(pg[s], ph[s], 1'b1, 2'(s));
      lru = up(lru, s);
    end
    for (int s = 0; s < 4; s++) lk(pg[s], 6'h3F, s);
    rd(TLBTA_CTRL_OFS, {pg[3], 12'hCC1});
    for (int m = 0; m < 4; m++) lk(pg[0], {2'(m), 4'hF}, m > 1 ? 0 : -1);
    v = $random(seed);
    k = lru[0] ? (lru[2] ? 3 : 2) : (lru[1] ? 1 : 0);
    old = pg[k];
    pg[k] = {v[19:5], 5'h1D};
    ph[k] = v[31:12];
    wt(pg[k], ph[k], 1'b0, 2'b00);
    lru = up(lru, k);
    lk(pg[k], 6'h3F, k);
    lk(old, 6'h3F, -1);
    end_of_test;
  end
endmodule : tlbta_tb_top
